// ===== can_gcs_pkg.sv
// Constants, register map and carrier types of the CAN global control and status block.
// Assumes an 8-bit special function register port driven by the host CPU core.

package can_gcs_pkg;

  // ----------------------------------------------------------------
  // Register addresses and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] GIT_ADDR = 8'h9B;
  localparam logic [7:0] GSTA_ADDR = 8'hAA;
  localparam logic [7:0] GCON_ADDR = 8'hAB;
  localparam logic [7:0] GIT_RESET = 8'h00;
  localparam logic [7:0] GSTA_RESET = 8'h00;
  localparam logic [7:0] GCON_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // General control bit positions
  // ----------------------------------------------------------------
  localparam int unsigned GCON_ABORT = 7;
  localparam int unsigned GCON_OVERLOAD = 6;
  localparam int unsigned GCON_TTC = 5;
  localparam int unsigned GCON_SYNC = 4;
  localparam int unsigned GCON_LISTEN = 3;
  localparam int unsigned GCON_TEST = 2;
  localparam int unsigned GCON_ENABLE = 1;
  localparam int unsigned GCON_SRESET = 0;

  // ----------------------------------------------------------------
  // General status bit positions
  // ----------------------------------------------------------------
  localparam int unsigned GSTA_OVERLOAD = 6;
  localparam int unsigned GSTA_TX_BUSY = 4;
  localparam int unsigned GSTA_RX_BUSY = 3;
  localparam int unsigned GSTA_ENABLED = 2;
  localparam int unsigned GSTA_BUS_OFF = 1;
  localparam int unsigned GSTA_ERR_PASSIVE = 0;

  // ----------------------------------------------------------------
  // General interrupt bit positions; bits 5..0 are sticky flags
  // ----------------------------------------------------------------
  localparam int unsigned GIT_GLOBAL = 7;
  localparam int unsigned GIT_FLAG_COUNT = 6;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [1:0] ENABLE_START_CYCLES = 2'h2;

  // Levels reported by the protocol engine
  typedef struct packed {
    logic frame_active;
    logic tx_frame;
    logic ack_tx;
    logic ifs_tx_pending;
    logic rx_frame;
    logic overload_tx;
    logic bus_off;
    logic error_passive;
  } engine_status_s;

  // One-cycle events from the protocol engine and CAN timer; low six bits in flag order
  typedef struct packed {
    logic sof;
    logic eof_last_bit;
    logic overload_start;
    logic timer_overrun;
    logic buffer_full;
    logic stuff_err;
    logic crc_err;
    logic form_err;
    logic ack_err;
  } engine_event_s;

  // Controls handed to the protocol engine, clock gate and message objects
  typedef struct packed {
    logic time_triggered_mode;
    logic timer_capture;
    logic listen_mode;
    logic test_mode;
    logic clock_enable;
    logic protocol_run;
    logic tx_recessive_hold;
    logic rx_enable;
    logic abort_request;
    logic object_enable_clear;
    logic overload_request;
  } core_ctrl_s;

endpackage

// ===== enable_sequencer.sv
// Enable and standby sequencing of the CAN protocol engine.
// Assumes frame_active is high from start of frame until the end of interframe handling.
`timescale 1ns/1ns
`default_nettype none

module enable_sequencer (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic soft_rst,
  input wire logic enable_req,
  input wire logic frame_active,
  output logic running,
  output logic clock_on
);

  typedef enum logic [1:0] {
    SEQ_OFF = 2'b00,
    SEQ_START = 2'b01,
    SEQ_RUN = 2'b10,
    SEQ_STOP = 2'b11
  } seq_state_e;

  seq_state_e state_q, state_d;
  logic [1:0] cnt_q, cnt_d;
  logic running_q, running_d;
  logic clock_on_q, clock_on_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      SEQ_OFF: begin
        cnt_d = 2'h0;
        if (enable_req) begin
          state_d = SEQ_START;
        end
      end
      SEQ_START: begin
        if (!enable_req) begin
          state_d = SEQ_OFF;
        end else if (cnt_q == can_gcs_pkg::ENABLE_START_CYCLES - 2'h1) begin
          state_d = SEQ_RUN;
        end else begin
          cnt_d = cnt_q + 2'h1;
        end
      end
      SEQ_RUN: begin
        if (!enable_req) begin
          state_d = frame_active ? SEQ_STOP : SEQ_OFF;
        end
      end
      SEQ_STOP: begin
        if (enable_req) begin
          state_d = SEQ_RUN;
        end else if (!frame_active) begin
          state_d = SEQ_OFF;
        end
      end
      default: state_d = SEQ_OFF;
    endcase
    if (soft_rst) begin
      state_d = SEQ_OFF;
      cnt_d = 2'h0;
    end
    running_d = (state_d == SEQ_RUN) || (state_d == SEQ_STOP);
    clock_on_d = (state_d != SEQ_OFF);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= SEQ_OFF;
      cnt_q <= 2'h0;
      running_q <= 1'b0;
      clock_on_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      running_q <= running_d;
      clock_on_q <= clock_on_d;
    end
  end

  assign running = running_q;
  assign clock_on = clock_on_q;

endmodule // enable_sequencer

`default_nettype wire

// ===== sticky_flags.sv
// Bank of sticky event flags, set by hardware and cleared by software.
// Assumes set and clear masks are one-cycle strobes.
`timescale 1ns/1ns
`default_nettype none

module sticky_flags #(
  parameter int unsigned WIDTH = 6
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic soft_rst,
  input wire logic [WIDTH-1:0] set_mask,
  input wire logic [WIDTH-1:0] clr_mask,
  output logic [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] flag_q, flag_d;

  // A set in the clearing cycle wins, so no event is lost
  for (genvar i = 0; i < WIDTH; i++) begin : g_flag
    always_comb begin
      flag_d[i] = set_mask[i] | (flag_q[i] & ~clr_mask[i] & ~soft_rst);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flags = flag_q;

endmodule // sticky_flags

`default_nettype wire

// ===== can_global_control_status.sv
// Global control, status and general interrupt registers of the CAN controller.
// Assumes an 8-bit SFR port: one-cycle sfr_wr/sfr_rd strobes, read data valid the cycle after.
`timescale 1ns/1ns
`default_nettype none

module can_global_control_status (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire can_gcs_pkg::engine_status_s eng_status,
  input wire can_gcs_pkg::engine_event_s eng_event,
  input wire logic irq_any,
  output can_gcs_pkg::core_ctrl_s core_ctrl,
  output logic controller_reset
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic wr_gcon, wr_git;

  always_comb begin
    wr_gcon = sfr_wr && (sfr_addr == can_gcs_pkg::GCON_ADDR);
    wr_git = sfr_wr && (sfr_addr == can_gcs_pkg::GIT_ADDR);
  end

  // ----------------------------------------------------------------
  // Software reset
  // ----------------------------------------------------------------
  // Held for exactly one cycle; every register below except the read data register treats it like the
  // hardware reset, except that an interrupt flag set in that cycle still sticks, and the bit itself reads back zero afterwards.
  logic sreset_q, sreset_d;

  always_comb begin
    sreset_d = wr_gcon && sfr_wdata[can_gcs_pkg::GCON_SRESET] && !sreset_q;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sreset_q <= 1'b0;
    end else begin
      sreset_q <= sreset_d;
    end
  end

  // ----------------------------------------------------------------
  // General control register
  // ----------------------------------------------------------------
  logic [7:0] gcon_q, gcon_d;
  logic abort_pulse_q, abort_pulse_d;

  always_comb begin
    gcon_d = gcon_q;
    abort_pulse_d = 1'b0;
    if (wr_gcon) begin
      gcon_d = sfr_wdata;
      gcon_d[can_gcs_pkg::GCON_SRESET] = 1'b0;
      abort_pulse_d = sfr_wdata[can_gcs_pkg::GCON_ABORT]
                      && !gcon_q[can_gcs_pkg::GCON_ABORT];
    end
    // Hardware clear of the overload request beats a simultaneous write
    if (gcon_q[can_gcs_pkg::GCON_OVERLOAD] && eng_event.overload_start) begin
      gcon_d[can_gcs_pkg::GCON_OVERLOAD] = 1'b0;
    end
    if (sreset_q) begin
      gcon_d = can_gcs_pkg::GCON_RESET;
      abort_pulse_d = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gcon_q <= can_gcs_pkg::GCON_RESET;
      abort_pulse_q <= 1'b0;
    end else begin
      gcon_q <= gcon_d;
      abort_pulse_q <= abort_pulse_d;
    end
  end

  // ----------------------------------------------------------------
  // Enable sequencing
  // ----------------------------------------------------------------
  logic running, clock_on;

  enable_sequencer u_seq (
    .clk(clk),
    .sys_rst(sys_rst),
    .soft_rst(sreset_q),
    .enable_req(gcon_q[can_gcs_pkg::GCON_ENABLE]),
    .frame_active(eng_status.frame_active),
    .running(running),
    .clock_on(clock_on)
  );

  // ----------------------------------------------------------------
  // Controls to the engine
  // ----------------------------------------------------------------
  can_gcs_pkg::core_ctrl_s ctrl_q, ctrl_d;
  logic ttc_on, sync_eof;

  always_comb begin
    ttc_on = gcon_q[can_gcs_pkg::GCON_TTC];
    sync_eof = gcon_q[can_gcs_pkg::GCON_SYNC];
    ctrl_d = '0;
    ctrl_d.time_triggered_mode = ttc_on;
    // Capture instant only matters in time-triggered mode
    ctrl_d.timer_capture = ttc_on && (sync_eof ? eng_event.eof_last_bit
                                               : eng_event.sof);
    ctrl_d.listen_mode = gcon_q[can_gcs_pkg::GCON_LISTEN];
    // Passed through unchanged; its effect lives in the engine
    ctrl_d.test_mode = gcon_q[can_gcs_pkg::GCON_TEST];
    ctrl_d.clock_enable = clock_on;
    ctrl_d.protocol_run = running;
    ctrl_d.tx_recessive_hold = !running;
    ctrl_d.rx_enable = running;
    ctrl_d.abort_request = gcon_q[can_gcs_pkg::GCON_ABORT];
    ctrl_d.object_enable_clear = abort_pulse_q;
    ctrl_d.overload_request = gcon_q[can_gcs_pkg::GCON_OVERLOAD];
    if (sreset_q) begin
      ctrl_d = '0;
      ctrl_d.tx_recessive_hold = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= '0;
      ctrl_q.tx_recessive_hold <= 1'b1;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ----------------------------------------------------------------
  // General status register
  // ----------------------------------------------------------------
  logic [7:0] gsta_q, gsta_d;

  // No write path exists, so software cannot touch these bits
  always_comb begin
    gsta_d = can_gcs_pkg::GSTA_RESET;
    gsta_d[can_gcs_pkg::GSTA_OVERLOAD] = eng_status.overload_tx;
    gsta_d[can_gcs_pkg::GSTA_TX_BUSY] = eng_status.tx_frame || eng_status.ack_tx
                                         || eng_status.ifs_tx_pending;
    gsta_d[can_gcs_pkg::GSTA_RX_BUSY] = eng_status.rx_frame;
    gsta_d[can_gcs_pkg::GSTA_ENABLED] = running;
    gsta_d[can_gcs_pkg::GSTA_BUS_OFF] = eng_status.bus_off;
    gsta_d[can_gcs_pkg::GSTA_ERR_PASSIVE] = eng_status.error_passive;
    if (sreset_q) begin
      gsta_d = can_gcs_pkg::GSTA_RESET;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gsta_q <= can_gcs_pkg::GSTA_RESET;
    end else begin
      gsta_q <= gsta_d;
    end
  end

  // ----------------------------------------------------------------
  // General interrupt register
  // ----------------------------------------------------------------
  localparam int unsigned NF = can_gcs_pkg::GIT_FLAG_COUNT;
  logic [NF-1:0] git_flags, git_set, git_clr;
  logic global_q, global_d;

  always_comb begin
    git_set = eng_event[NF-1:0];
    // Writing zero to a flag clears it; writing one leaves it alone
    git_clr = wr_git ? ~sfr_wdata[NF-1:0] : '0;
    global_d = irq_any && !sreset_q;
  end

  sticky_flags #(
    .WIDTH(NF)
  ) u_git (
    .clk(clk),
    .sys_rst(sys_rst),
    .soft_rst(sreset_q),
    .set_mask(git_set),
    .clr_mask(git_clr),
    .flags(git_flags)
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      global_q <= 1'b0;
    end else begin
      global_q <= global_d;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Always open, whatever the enable state
  logic [7:0] rdata_q, rdata_d;

  always_comb begin
    rdata_d = rdata_q;
    if (sfr_rd) begin
      case (sfr_addr)
        can_gcs_pkg::GCON_ADDR: rdata_d = gcon_q;
        can_gcs_pkg::GSTA_ADDR: rdata_d = gsta_q;
        can_gcs_pkg::GIT_ADDR: rdata_d = {global_q, 1'b0, git_flags};
        default: rdata_d = can_gcs_pkg::UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= can_gcs_pkg::UNMAPPED_READ;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign sfr_rdata = rdata_q;
  assign core_ctrl = ctrl_q;
  assign controller_reset = sreset_q;

endmodule // can_global_control_status

`default_nettype wire

// ===== can_gcs_properties.sv
// Concurrent checks on the ports of the CAN global control and status block.
// Assumes it is bound to can_global_control_status, one clock, async reset.
`timescale 1ns/1ns
`default_nettype none

module can_gcs_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire can_gcs_pkg::engine_status_s eng_status,
  input wire can_gcs_pkg::engine_event_s eng_event,
  input wire logic irq_any,
  input wire can_gcs_pkg::core_ctrl_s core_ctrl,
  input wire logic controller_reset
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  can_gcs_pkg::engine_status_s st_q;
  logic irq_q;
  always_ff @(posedge clk) begin
    st_q <= eng_status;
    irq_q <= irq_any;
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_start_delay: assert property (
    $rose(core_ctrl.protocol_run) |-> $past(core_ctrl.clock_enable, 2))
    else $error("engine started early");
  chk_standby_hold: assert property (
    !core_ctrl.protocol_run |-> core_ctrl.tx_recessive_hold && !core_ctrl.rx_enable)
    else $error("standby outputs wrong");
  chk_frame_finish: assert property (
    core_ctrl.protocol_run && eng_status.frame_active && !controller_reset
    |=> core_ctrl.protocol_run)
    else $error("engine stopped in mid-frame");
  chk_sreset_pulse: assert property (
    sfr_wr && sfr_addr == can_gcs_pkg::GCON_ADDR && sfr_wdata[0]
    |=> controller_reset ##1 !controller_reset)
    else $error("software reset pulse wrong");
  chk_reset_disables: assert property (
    controller_reset |=> !core_ctrl.clock_enable && !core_ctrl.protocol_run)
    else $error("controller left enabled by reset");
  chk_status_map: assert property (
    sfr_rd && sfr_addr == can_gcs_pkg::GSTA_ADDR && $stable(eng_status) && !controller_reset
    |=> sfr_rdata[6] == st_q.overload_tx && sfr_rdata[3] == st_q.rx_frame
      && sfr_rdata[4] == (st_q.tx_frame | st_q.ack_tx | st_q.ifs_tx_pending)
      && sfr_rdata[1:0] == {st_q.bus_off, st_q.error_passive})
    else $error("status read wrong");
  chk_reserved_zero: assert property (
    sfr_rd && sfr_addr == can_gcs_pkg::GSTA_ADDR |=> !sfr_rdata[7] && !sfr_rdata[5])
    else $error("reserved status bits set");
  chk_global_irq: assert property (
    sfr_rd && sfr_addr == can_gcs_pkg::GIT_ADDR && $stable(irq_any) && !controller_reset
    |=> sfr_rdata[7] == irq_q && !sfr_rdata[6])
    else $error("global interrupt bit wrong");
  chk_capture_gate: assert property (
    core_ctrl.timer_capture |-> $past(core_ctrl.time_triggered_mode)
      && ($past(eng_event.sof) || $past(eng_event.eof_last_bit)))
    else $error("capture without cause");
  chk_overload_clear: assert property (
    core_ctrl.overload_request && eng_event.overload_start |=> ##1 !core_ctrl.overload_request)
    else $error("overload request not cleared");
  chk_abort_pulse: assert property (
    $rose(core_ctrl.abort_request) |-> ##[0:2] core_ctrl.object_enable_clear)
    else $error("object enable clear missing");
  cov_run: cover property ($rose(core_ctrl.protocol_run));
  cov_sreset: cover property (controller_reset);
  cov_capture: cover property (core_ctrl.timer_capture);
endmodule // can_gcs_properties

bind can_global_control_status can_gcs_properties u_props (
  .clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .eng_status(eng_status),
  .eng_event(eng_event), .irq_any(irq_any), .core_ctrl(core_ctrl),
  .controller_reset(controller_reset)
);
`default_nettype wire

// ===== can_engine_model.sv
// Behavioural model of the protocol engine and bus side feeding the block.
// Assumes the testbench calls its tasks just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none

module can_engine_model (
  input wire logic clk,
  output var can_gcs_pkg::engine_status_s eng_status,
  output var can_gcs_pkg::engine_event_s eng_event,
  output var logic irq_any
);
  initial begin
    eng_status = '0;
    eng_event = '0;
    irq_any = 1'b0;
  end
  // Events last exactly one cycle, as the block expects
  task automatic pulse(input can_gcs_pkg::engine_event_s ev);
    @(posedge clk);
    #1 eng_event = ev;
    @(posedge clk);
    #1 eng_event = '0;
  endtask
  task automatic set_status(input can_gcs_pkg::engine_status_s s);
    eng_status = s;
  endtask
  task automatic set_irq(input logic on);
    irq_any = on;
  endtask
endmodule // can_engine_model
`default_nettype wire

// ===== tb_top.sv
// Self-checking testbench of the CAN global control and status block.
// Assumes the engine model on the far side and the bound property checker.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  localparam logic [7:0] con_a = can_gcs_pkg::GCON_ADDR;
  localparam logic [7:0] sta_a = can_gcs_pkg::GSTA_ADDR;
  localparam logic [7:0] git_a = can_gcs_pkg::GIT_ADDR;
  logic clk = 1'b0;
  logic sys_rst;
  logic [7:0] sfr_addr;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  can_gcs_pkg::engine_status_s eng_status;
  can_gcs_pkg::engine_event_s eng_event;
  logic irq_any;
  can_gcs_pkg::core_ctrl_s core_ctrl;
  logic controller_reset;
  logic [7:0] cap_cnt = 8'h00;
  logic [7:0] ob_cnt = 8'h00;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;

  always #20 clk = ~clk;

  can_global_control_status u_dut (
    .clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .eng_status(eng_status),
    .eng_event(eng_event), .irq_any(irq_any), .core_ctrl(core_ctrl),
    .controller_reset(controller_reset)
  );
  can_engine_model u_eng (.clk(clk), .eng_status(eng_status), .eng_event(eng_event),
    .irq_any(irq_any));

  always @(posedge clk) begin
    if (core_ctrl.timer_capture === 1'b1) cap_cnt <= cap_cnt + 8'h01;
    if (core_ctrl.object_enable_clear === 1'b1) ob_cnt <= ob_cnt + 8'h01;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      print_verdict();
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic ck1(input logic seen, input logic exp);
    check({7'h00, seen}, {7'h00, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk);
    #1 sfr_wr = 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1 sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk);
    #1 sfr_rd = 1'b0;
    check(sfr_rdata, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic [7:0] sta_exp(input logic [7:0] s);
    return {1'b0, s[2], 1'b0, |s[6:4], s[3], 1'b0, s[1:0]};
  endfunction
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values;
    rchk(git_a, 8'h00);
    rchk(sta_a, 8'h00);
    rchk(con_a, 8'h00);
    rchk(8'h9A, can_gcs_pkg::UNMAPPED_READ);
    ck1(core_ctrl.tx_recessive_hold, 1'b1);
  endtask
  task automatic t_enable_disable;
    wr(con_a, 8'h02);
    cyc(2);
    ck1(core_ctrl.clock_enable, 1'b1);
    ck1(core_ctrl.protocol_run, 1'b0);
    cyc(1);
    ck1(core_ctrl.protocol_run, 1'b0);
    cyc(1);
    ck1(core_ctrl.protocol_run, 1'b1);
    ck1(core_ctrl.tx_recessive_hold, 1'b0);
    rchk(sta_a, 8'h04);
    u_eng.set_status(8'h88);
    wr(con_a, 8'h00);
    cyc(6);
    ck1(core_ctrl.protocol_run, 1'b1);
    u_eng.set_status(8'h00);
    cyc(4);
    ck1(core_ctrl.protocol_run, 1'b0);
    ck1(core_ctrl.rx_enable, 1'b0);
    rchk(sta_a, 8'h00);
  endtask
  task automatic t_status;
    for (int i = 0; i < 8; i++) begin
      u_eng.set_status(8'h01 << i);
      // Let the status settle so the checker's stability guard also holds
      cyc(1);
      rchk(sta_a, sta_exp(8'h01 << i));
    end
    u_eng.set_status(8'h00);
    wr(sta_a, 8'h5F);
    rchk(sta_a, 8'h00);
  endtask
  task automatic t_flags;
    for (int i = 0; i < 6; i++) u_eng.pulse(9'h001 << i);
    rchk(git_a, 8'h3F);
    wr(git_a, 8'h3F);
    rchk(git_a, 8'h3F);
    wr(git_a, 8'h37);
    rchk(git_a, 8'h37);
    u_eng.set_irq(1'b1);
    rchk(git_a, 8'hB7);
    wr(git_a, 8'h00);
    rchk(git_a, 8'h80);
    u_eng.set_irq(1'b0);
    rchk(git_a, 8'h00);
  endtask
  task automatic t_capture;
    logic [7:0] base;
    for (int m = 0; m < 4; m++) begin
      wr(con_a, {2'b00, m[1:0], 4'h0});
      base = cap_cnt;
      u_eng.pulse(9'h100);
      cyc(2);
      check(cap_cnt - base, {7'h00, m == 2});
      u_eng.pulse(9'h080);
      cyc(2);
      check(cap_cnt - base, {7'h00, m[1]});
      ck1(core_ctrl.time_triggered_mode, m[1]);
    end
  endtask
  task automatic t_abort_overload;
    logic [7:0] base;
    base = ob_cnt;
    wr(con_a, 8'h80);
    cyc(3);
    check(ob_cnt - base, 8'h01);
    ck1(core_ctrl.abort_request, 1'b1);
    wr(con_a, 8'h40);
    cyc(1);
    ck1(core_ctrl.overload_request, 1'b1);
    u_eng.pulse(9'h040);
    cyc(1);
    ck1(core_ctrl.overload_request, 1'b0);
    rchk(con_a, 8'h00);
    check(ob_cnt - base, 8'h01);
  endtask
  task automatic t_listen;
    wr(con_a, 8'h08); // test bit left clear
    cyc(1);
    ck1(core_ctrl.listen_mode, 1'b1);
    rchk(con_a, 8'h08);
    wr(con_a, 8'h00);
    cyc(1);
    ck1(core_ctrl.listen_mode, 1'b0);
  endtask
  task automatic t_soft_reset;
    wr(con_a, 8'h2A);
    cyc(4);
    ck1(core_ctrl.protocol_run, 1'b1);
    wr(con_a, 8'h2B);
    ck1(controller_reset, 1'b1);
    cyc(1);
    ck1(controller_reset, 1'b0);
    cyc(1);
    ck1(core_ctrl.clock_enable, 1'b0);
    rchk(con_a, 8'h00);
    rchk(sta_a, 8'h00);
  endtask
  task automatic t_hw_reset;
    wr(con_a, 8'h02);
    cyc(4);
    ck1(core_ctrl.protocol_run, 1'b1);
    // Hardware reset in mid-run must also leave the controller disabled
    sys_rst = 1'b1;
    cyc(2);
    sys_rst = 1'b0;
    ck1(core_ctrl.protocol_run, 1'b0);
    ck1(core_ctrl.clock_enable, 1'b0);
    rchk(con_a, 8'h00);
    rchk(sta_a, 8'h00);
  endtask

  initial begin
    sys_rst = 1'b1;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    cyc(8);
    sys_rst = 1'b0;
    t_reset_values();
    t_enable_disable();
    t_status();
    t_flags();
    t_capture();
    t_abort_overload();
    t_listen();
    t_soft_reset();
    t_hw_reset();
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
